// *** adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [4:0] result_high_off   = 5'h00;
  localparam logic [4:0] result_low_off    = 5'h04;
  localparam logic [4:0] control_a_off     = 5'h08;
  localparam logic [4:0] control_b_off     = 5'h0c;
  localparam logic [4:0] pin_select_off    = 5'h10;
  // ==========================================================================
  // Field positions and reset values
  localparam int         start_bit         = 7;
  localparam int         busy_bit          = 6;
  localparam int         enable_bit        = 5;
  localparam int         align_bit         = 4;
  localparam logic [7:0] control_a_rst     = 8'h00;
  localparam logic [7:0] control_b_rst     = 8'h00;
  localparam logic [7:0] pin_select_rst    = 8'h00;
  localparam logic [2:0] source_bandgap    = 3'h1;
  localparam logic [1:0] ref_internal      = 2'h1;
  localparam int         ref_shared_pin    = 4;
  localparam logic [1:0] resp_okay         = 2'h0;
  localparam logic [1:0] resp_slverr       = 2'h2;
  // ==========================================================================
  // Converter input routing, carried to the analog core
  typedef enum logic [1:0] {src_external, src_bandgap, src_ground} source_t;
  typedef struct packed {
    logic       power_on;
    source_t    source;
    logic       channel_valid;
    logic [2:0] channel;
    logic       ref_from_pin;
    logic [2:0] clock_divider;
  } analog_ctrl_t;
endpackage

// *** adc_control_registers.sv ***
// What this block does
// (R01) Twelve-bit result held in two byte registers, twelve of sixteen bits used.
// (R02) Alignment 0: high byte bits 11..4, low byte upper nibble bits 3..0.
// (R03) Alignment 1: high byte lower nibble bits 11..8, low byte bits 7..0.
// (R04) Unused result bit positions read as zero.
// (R05) Converter disabled: power off and result registers keep their contents.
// (R06) Writing start high then low begins a conversion.
// (R07) Busy flag rises on start and falls when the conversion completes.
// (R08) Software sets converter enable before use; clearing powers the converter down.
// (R09) Channel codes 0..7 route input n; top bit set selects nothing.
// (R10) Software programs source 000, 101 or 11x for external channels.
// (R11) Source 000,101..111 external; 001 bandgap; 010..100 ground.
// (R12) With bandgap source, software sets channel code top bit.
// (R13) Reference code 01 selects supply; 00 and 1x the reference pin.
// (R14) With internal supply reference software keeps reference pin enable cleared.
// (R15) Converter clock is system clock divided by two to the code, and by two for code 0.
// (R16) Pin analog enable bit hands pin n to analog input n.
// (R17) Pull-high disconnected while a pin is an analog input.
// (R18) Reference pin enable removes analog role from shared pin.
// (R19) Completion pulses an interrupt request for one clock to the interrupt controller.
// (R20) Latency is a parameter in converter clocks, in system clocks for code 0; result loads as busy falls.
`timescale 1ns/1ns
module adc_control_registers #(
  parameter int conv_cycles = 16
) (
  // Clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_sys_rst,
  // AXI4-Lite write address, data and response
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [4:0]                 i_awaddr,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  output logic [1:0]                      o_bresp,
  // AXI4-Lite read
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  input  wire logic [4:0]                 i_araddr,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  // Converter core
  input  wire logic [11:0]                i_conv_data,
  output adc_ctrl_pkg::analog_ctrl_t      o_analog_ctrl,
  output logic                            o_conv_clk,
  output logic                            o_conv_done,
  // Pin multiplexer
  input  wire logic                       i_ref_pin_enable,
  output logic [7:0]                      o_pin_analog,
  output logic [7:0]                      o_pullhigh_off
);
  import adc_ctrl_pkg::*;

  // ==========================================================================
  // Register storage
  logic       start_reg;
  logic       busy_reg;
  logic [5:0] control_a_reg;
  logic [7:0] control_b_reg;
  logic [7:0] pin_select_reg;
  logic [11:0] result_reg;
  logic [6:0] div_cnt_reg;
  logic [15:0] conv_cnt_reg;
  logic       done_reg;
  logic       conv_clk_reg;
  logic       ref_pin_s1_reg;
  logic       ref_pin_s2_reg;

  wire        enable_w   = control_a_reg[enable_bit];
  wire        align_w    = control_a_reg[align_bit];
  wire [3:0]  chan_w     = control_a_reg[3:0];
  wire [2:0]  source_w   = control_b_reg[7:5];
  wire [1:0]  refsel_w   = control_b_reg[4:3];
  wire [2:0]  divsel_w   = control_b_reg[2:0];

  // ==========================================================================
  // Write channel: both address and data taken together
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  wire        wr_go     = i_awvalid && i_wvalid && !bvalid_reg;
  wire        wr_byte   = wr_go && i_wstrb[0];
  wire        wr_a      = wr_byte && (i_awaddr == control_a_off);
  wire        wr_b      = wr_byte && (i_awaddr == control_b_off);
  wire        wr_pins   = wr_byte && (i_awaddr == pin_select_off);
  wire        wr_mapped = (i_awaddr == control_a_off) || (i_awaddr == control_b_off) ||
                          (i_awaddr == pin_select_off) || (i_awaddr == result_high_off) ||
                          (i_awaddr == result_low_off);
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;

  // Start falling edge written by software
  wire        start_fall = wr_a && start_reg && !i_wdata[start_bit]; // R06

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      bvalid_reg     <= 1'b0;
      bresp_reg      <= resp_okay;
      start_reg      <= control_a_rst[start_bit];
      control_a_reg  <= control_a_rst[5:0];
      control_b_reg  <= control_b_rst;
      pin_select_reg <= pin_select_rst;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? resp_okay : resp_slverr;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_a) begin
        start_reg     <= i_wdata[start_bit];
        control_a_reg <= i_wdata[5:0];
      end
      if (wr_b) begin
        control_b_reg <= i_wdata[7:0];
      end
      if (wr_pins) begin
        pin_select_reg <= i_wdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Converter clock divider and conversion sequencing
  wire [6:0] div_max  = 7'((8'h01 << divsel_w) - 8'h01); // R15
  wire       div_tick = (div_cnt_reg >= div_max);
  wire       conv_end = busy_reg && div_tick && (conv_cnt_reg == 16'(conv_cycles - 1));

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      div_cnt_reg    <= 7'h00;
      conv_clk_reg   <= 1'b0;
      busy_reg       <= 1'b0;
      conv_cnt_reg   <= 16'h0000;
      done_reg       <= 1'b0;
      result_reg     <= 12'h000;
      ref_pin_s1_reg <= 1'b0;
      ref_pin_s2_reg <= 1'b0;
    end else begin
      ref_pin_s1_reg <= i_ref_pin_enable;
      ref_pin_s2_reg <= ref_pin_s1_reg;
      div_cnt_reg    <= (div_tick || !enable_w) ? 7'h00 : div_cnt_reg + 7'h01; // R15
      conv_clk_reg   <= enable_w && (divsel_w == 3'h0 ? !conv_clk_reg : !div_tick);
      done_reg       <= conv_end; // R19
      if (!enable_w) begin
        busy_reg <= 1'b0; // R05
      end else if (start_fall && !busy_reg) begin
        busy_reg     <= 1'b1; // R07
        conv_cnt_reg <= 16'h0000;
      end else if (conv_end) begin
        busy_reg   <= 1'b0; // R07
        result_reg <= i_conv_data; // R20
      end else if (busy_reg && div_tick) begin
        conv_cnt_reg <= conv_cnt_reg + 16'h0001; // R20
      end
    end
  end

  // ==========================================================================
  // Result formatting
  wire [7:0] result_high = align_w ? {4'h0, result_reg[11:8]} : result_reg[11:4]; // R02 R03 R04
  wire [7:0] result_low  = align_w ? result_reg[7:0] : {result_reg[3:0], 4'h0}; // R01 R04

  // ==========================================================================
  // Read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  wire         rd_go = i_arvalid && !rvalid_reg;
  wire [7:0]   ctrl_a_view = {start_reg, busy_reg, control_a_reg[5:0]};
  wire         rd_hit = (i_araddr == result_high_off) || (i_araddr == result_low_off) ||
                        (i_araddr == control_a_off) || (i_araddr == control_b_off) ||
                        (i_araddr == pin_select_off);
  wire [7:0]   rd_byte = (i_araddr == result_high_off) ? result_high :
                         (i_araddr == result_low_off)  ? result_low  :
                         (i_araddr == control_a_off)   ? ctrl_a_view :
                         (i_araddr == control_b_off)   ? control_b_reg :
                         (i_araddr == pin_select_off)  ? pin_select_reg : 8'h00;
  assign o_arready = rd_go;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= resp_okay;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_hit ? resp_okay : resp_slverr;
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Analog routing and pin control
  wire       src_ext  = (source_w == 3'h0) || (source_w >= 3'h5); // R11
  wire       src_bg   = (source_w == source_bandgap); // R11
  wire [7:0] ref_mask = ref_pin_s2_reg ? (8'h01 << ref_shared_pin) : 8'h00; // R18

  assign o_analog_ctrl.power_on      = enable_w; // R05
  assign o_analog_ctrl.source        = src_ext ? src_external : (src_bg ? src_bandgap : src_ground);
  assign o_analog_ctrl.channel_valid = !chan_w[3]; // R09
  assign o_analog_ctrl.channel       = chan_w[2:0]; // R09
  assign o_analog_ctrl.ref_from_pin  = (refsel_w != ref_internal); // R13
  assign o_analog_ctrl.clock_divider = divsel_w; // R15
  assign o_conv_clk     = conv_clk_reg;
  assign o_conv_done    = done_reg; // R19
  assign o_pin_analog   = pin_select_reg & ~ref_mask; // R16 R18
  assign o_pullhigh_off = pin_select_reg & ~ref_mask; // R17

  // ==========================================================================
  // Assertions
  sequence s_start;
    start_fall && !busy_reg && enable_w;
  endsequence
  property p_busy_rise;
    @(posedge i_ref_clk) disable iff (i_sys_rst) s_start |=> busy_reg;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not set"); // R07
  property p_done_pulse;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      $fell(busy_reg) && $past(enable_w) |-> o_conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("no done"); // R19
  property p_result_hold;
    @(posedge i_ref_clk) disable iff (i_sys_rst) !enable_w |=> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed"); // R05
  property p_align0;
    @(posedge i_ref_clk) disable iff (i_sys_rst) !align_w |-> result_low[3:0] == 4'h0;
  endproperty
  a_align0: assert property (p_align0) else $error("low nibble set"); // R04
  property p_align1;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      align_w |-> {result_high[3:0], result_low} == result_reg && result_high[7:4] == 4'h0;
  endproperty
  a_align1: assert property (p_align1) else $error("bad right align"); // R03
  property p_bandgap;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      source_w == 3'h1 |-> o_analog_ctrl.source == src_bandgap;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bad source"); // R11
  property p_ref;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      refsel_w == 2'h1 |-> !o_analog_ctrl.ref_from_pin;
  endproperty
  a_ref: assert property (p_ref) else $error("bad reference"); // R13
  property p_pull;
    @(posedge i_ref_clk) disable iff (i_sys_rst) o_pullhigh_off == o_pin_analog;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-high mismatch"); // R17
  sequence s_finish;
    conv_end && enable_w;
  endsequence
  property p_result_load;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      s_finish |=> result_reg == $past(i_conv_data);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded"); // R20
  property p_busy_abort;
    @(posedge i_ref_clk) disable iff (i_sys_rst) !enable_w |=> !busy_reg;
  endproperty
  a_busy_abort: assert property (p_busy_abort) else $error("busy while disabled"); // R05
  property p_conv_clk_off;
    @(posedge i_ref_clk) disable iff (i_sys_rst) !enable_w |=> !o_conv_clk;
  endproperty
  a_conv_clk_off: assert property (p_conv_clk_off) else $error("clock while disabled"); // R05
  property p_done_idle;
    @(posedge i_ref_clk) disable iff (i_sys_rst) o_conv_done |-> !busy_reg;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done"); // R07
  property p_align0_map;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !align_w |-> result_high == result_reg[11:4] && result_low[7:4] == result_reg[3:0];
  endproperty
  a_align0_map: assert property (p_align0_map) else $error("bad left align"); // R02
  property p_ground;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      source_w inside {3'h2, 3'h3, 3'h4} |-> o_analog_ctrl.source == src_ground;
  endproperty
  a_ground: assert property (p_ground) else $error("ground not routed"); // R11
  property p_external;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      source_w inside {3'h0, 3'h5, 3'h6, 3'h7} |-> o_analog_ctrl.source == src_external;
  endproperty
  a_external: assert property (p_external) else $error("external not routed"); // R11
  property p_no_channel;
    @(posedge i_ref_clk) disable iff (i_sys_rst) chan_w[3] |-> !o_analog_ctrl.channel_valid;
  endproperty
  a_no_channel: assert property (p_no_channel) else $error("channel not floating"); // R09
  property p_ref_pin;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      ref_pin_s2_reg |-> !o_pin_analog[ref_shared_pin];
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("shared pin still analog"); // R18
  property p_pin_route;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !ref_pin_s2_reg |-> o_pin_analog == pin_select_reg;
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin routing mismatch"); // R16
endmodule

// *** conv_core_model.sv ***
`timescale 1ns/1ns
module conv_core_model
  import adc_ctrl_pkg::*;
(
  // Clock and routing
  input  wire logic                  i_clk,
  input  wire adc_ctrl_pkg::analog_ctrl_t i_ctrl,
  // Converted value
  output logic [11:0]                o_data = 12'h5a5
);
  // ==========================================================================
  // Converter core and input multiplexer
  always @(posedge i_clk) begin
    if (!i_ctrl.power_on) begin
      o_data <= ~o_data;
    end else if (i_ctrl.source == src_bandgap) begin
      o_data <= 12'h7e1;
    end else if (i_ctrl.source == src_ground) begin
      o_data <= 12'h000;
    end else if (!i_ctrl.channel_valid) begin
      o_data <= ~o_data;
    end else begin
      o_data <= {1'b1, i_ctrl.channel, 8'h3c};
    end
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
  logic ar_v = 1'b0, r_rdy = 1'b0, ref_en = 1'b0, p;
  logic [4:0] aw_a = 5'h00, ar_a = 5'h00;
  logic [31:0] w_d = 32'h0, r_d;
  logic aw_r, w_r, b_v, ar_r, r_v, cclk, done;
  logic [1:0] b_rsp, r_rsp, e_src;
  logic [11:0] cdata;
  logic [7:0] pins, pulls;
  analog_ctrl_t actl;
  int error_cnt = 0, n_checks = 0, n;
  always #2 clk = ~clk;
  adc_control_registers #(.conv_cycles(4)) dut (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_awvalid(aw_v), .o_awready(aw_r), .i_awaddr(aw_a), .i_wvalid(w_v), .o_wready(w_r),
    .i_wdata(w_d), .i_wstrb(4'hf), .o_bvalid(b_v), .i_bready(b_rdy), .o_bresp(b_rsp),
    .i_arvalid(ar_v), .o_arready(ar_r), .i_araddr(ar_a), .o_rvalid(r_v), .i_rready(r_rdy),
    .o_rdata(r_d), .o_rresp(r_rsp), .i_conv_data(cdata), .o_analog_ctrl(actl),
    .o_conv_clk(cclk), .o_conv_done(done), .i_ref_pin_enable(ref_en),
    .o_pin_analog(pins), .o_pullhigh_off(pulls));
  conv_core_model core (.i_clk(clk), .i_ctrl(actl), .o_data(cdata));
  // ==========================================================================
  // Bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = resp_okay);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do @(posedge clk); while (!(aw_r && w_r));
    aw_v <= 1'b0;
    w_v <= 1'b0;
    do @(posedge clk); while (!b_v);
    chk(32'(b_rsp), 32'(er));
  endtask
  task rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = resp_okay);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do @(posedge clk); while (!ar_r);
    ar_v <= 1'b0;
    do @(posedge clk); while (!r_v);
    chk(32'(r_rsp), 32'(er));
    if (er == resp_okay) chk(r_d, {24'h0, d});
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(result_high_off, 8'h00);
    rd(control_a_off, 8'h00);
    rd(control_b_off, 8'h00);
    rd(pin_select_off, 8'h00);
    rd(5'h14, 8'h00, resp_slverr);
    wr(5'h14, 8'hff, resp_slverr);
    wr(result_high_off, 8'hff);
    rd(result_high_off, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(control_b_off, {s[2:0], s[1:0], s[2:0]});
      e_src = (s == 1) ? src_bandgap : (s >= 2 && s <= 4) ? src_ground : src_external;
      chk(32'(actl.source), 32'(e_src));
      chk(32'(actl.ref_from_pin), 32'(s[1:0] != ref_internal));
      chk(32'(actl.clock_divider), 32'(s[2:0]));
      rd(control_b_off, {s[2:0], s[1:0], s[2:0]});
    end
    for (int c = 0; c < 16; c++) begin
      wr(control_a_off, {4'h2, c[3:0]});
      chk(32'(actl.channel_valid), 32'(!c[3]));
      if (!c[3]) chk(32'(actl.channel), 32'(c[2:0]));
    end
    wr(pin_select_off, 8'hf5);
    chk(32'(pins), 32'h0f5);
    chk(32'(pulls), 32'h0f5);
    ref_en <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pins), 32'h0e5);
    chk(32'(pulls), 32'h0e5);
    wr(control_b_off, 8'h02);
    wr(control_a_off, 8'ha3);
    rd(control_a_off, 8'ha3);
    wr(control_a_off, 8'h23);
    rd(control_a_off, 8'h63);
    do begin p = cclk; @(posedge clk); end while (!(cclk && !p));
    n = 0;
    do begin p = cclk; @(posedge clk); n++; end while (!(cclk && !p));
    chk(n, 4);
    n = 0;
    while (!done && n < 2000) begin @(posedge clk); n++; end
    chk(32'(done), 32'h1);
    @(posedge clk);
    chk(32'(done), 32'h0);
    rd(control_a_off, 8'h23);
    rd(result_high_off, 8'hb3);
    rd(result_low_off, 8'hc0);
    wr(control_a_off, 8'h33);
    rd(result_high_off, 8'h0b);
    rd(result_low_off, 8'h3c);
    wr(control_a_off, 8'hb5);
    wr(control_a_off, 8'h35);
    wr(control_a_off, 8'h15);
    chk(32'(actl.power_on), 32'h0);
    rd(control_a_off, 8'h15);
    repeat (40) begin @(posedge clk); if (done) chk(32'(done), 32'h0); end
    rd(result_high_off, 8'h0b);
    rd(result_low_off, 8'h3c);
    results;
  end
  initial begin
    #40000;
    error_cnt++;
    $display("BAD %0t timeout", $time);
    results;
  end
endmodule
